// [rtl/spp_pin_cell.sv]
// Purpose: Output ownership and input gating for one pin
// Assumes: All inputs on clk_i, pin level already synchronized
// Notes:   Purely combinational, the top registers the results
`timescale 1ns/100ps
module spp_pin_cell (
  input  wire logic dir_i,
  input  wire logic latch_i,
  input  wire logic od_i,
  input  wire logic periph_en_i,
  input  wire logic periph_drive_i,
  input  wire logic periph_out_i,
  input  wire logic analog_i,
  input  wire logic pin_sync_i,
  input  wire logic impl_i,
  output logic      owns_o,
  output logic      port_drives_o,
  output logic      pin_out_o,
  output logic      pin_oe_o,
  output logic      periph_in_o,
  output logic      read_bit_o
);

  logic data;
  logic drive;

  // ----------------------------------------------------------------
  // Output multiplexers
  // ----------------------------------------------------------------
  assign owns_o        = impl_i & periph_en_i & periph_drive_i;
  assign data          = owns_o ? periph_out_i : latch_i;
  assign drive         = impl_i & (owns_o | ~dir_i);
  assign port_drives_o = impl_i & ~owns_o & ~dir_i;
  assign pin_out_o     = data & ~od_i;
  assign pin_oe_o      = drive & ~(od_i & data);

  // ----------------------------------------------------------------
  // Input paths
  // ----------------------------------------------------------------
  assign periph_in_o = impl_i & pin_sync_i & ~port_drives_o & ~analog_i;
  assign read_bit_o  = impl_i & pin_sync_i & ~analog_i;

endmodule : spp_pin_cell

// [rtl/spp_pkg.sv]
// Purpose: Constants for the shared pin parallel port
// Assumes: Classic Wishbone slave, 32-bit data, one word per register
// Notes:   Offsets are byte addresses; registers hold at most 16 bits
//
// Overview of operation
// - Per pin, mux picks peripheral or port
// - Driving peripheral disables port driver, pin readable
// - Enabled idle peripheral lets port drive pin
// - Port output never loops into peripheral input
// - Direction one is input, zero is output
// - Reset makes every pin an input
// - Latch write stores, latch read returns latch
// - Level read returns pins, write hits latch
// - Unimplemented bits disabled and read zero
// - Input-only shared pin acts as dedicated
// - Open-drain bit drives low only, releases high
// - Select bit clear analog, set digital
// - Analog-capable pins reset to analog mode
// - Either converter clear makes pin analog
// - Analog pins read zero on level register
// - Digital pins are not connected to converter
package spp_pkg;

  // ----------------------------------------------------------------
  // Bus and widths
  // ----------------------------------------------------------------
  localparam int SPP_MAX_WIDTH   = 16;
  localparam int SPP_REG_W       = 16;
  localparam int SPP_ADR_W       = 5;
  localparam int SPP_DATA_W      = 32;
  localparam int SPP_SEL_W       = 4;
  localparam int SPP_SYNC_STAGES = 2;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [SPP_ADR_W-1:0] SPP_OFF_DIR    = 5'h00;
  localparam logic [SPP_ADR_W-1:0] SPP_OFF_LATCH  = 5'h04;
  localparam logic [SPP_ADR_W-1:0] SPP_OFF_LEVEL  = 5'h08;
  localparam logic [SPP_ADR_W-1:0] SPP_OFF_OD     = 5'h0c;
  localparam logic [SPP_ADR_W-1:0] SPP_OFF_C1_LOW = 5'h10;
  localparam logic [SPP_ADR_W-1:0] SPP_OFF_C1_HIGH = 5'h14;
  localparam logic [SPP_ADR_W-1:0] SPP_OFF_C2_LOW = 5'h18;
  localparam logic [SPP_ADR_W-1:0] SPP_OFF_C2_HIGH = 5'h1c;

  // ----------------------------------------------------------------
  // Reset values and default pin maps
  // ----------------------------------------------------------------
  localparam logic [SPP_REG_W-1:0] SPP_DIR_RESET    = 16'hffff;
  localparam logic [SPP_REG_W-1:0] SPP_LATCH_RESET  = 16'h0000;
  localparam logic [SPP_REG_W-1:0] SPP_OD_RESET     = 16'h0000;
  localparam logic [SPP_REG_W-1:0] SPP_ASEL_RESET   = 16'h0000;
  localparam logic [SPP_REG_W-1:0] SPP_IMPL_DEFAULT = 16'hffff;
  localparam logic [SPP_REG_W-1:0] SPP_ANA_DEFAULT  = 16'h00ff;
  localparam logic [SPP_REG_W-1:0] SPP_BANK_DEFAULT = 16'h00c0;

endpackage : spp_pkg

// [rtl/spp_port.sv]
// Purpose: Shared pin parallel port with Wishbone register access
// Assumes: Single clock, synchronous active high reset
// Notes:   One-cycle registered ack; pins sampled through two flops
//
// Local design decisions: the placing of the registers and the Wishbone register port.
`timescale 1ns/100ps
module spp_port
  import spp_pkg::*;
#(
  parameter int                    PORT_WIDTH   = SPP_MAX_WIDTH,
  parameter logic [PORT_WIDTH-1:0] IMPL_MASK    = SPP_IMPL_DEFAULT[PORT_WIDTH-1:0],
  parameter logic [PORT_WIDTH-1:0] ANALOG_MASK  = SPP_ANA_DEFAULT[PORT_WIDTH-1:0],
  parameter logic [PORT_WIDTH-1:0] ANALOG_BANK  = SPP_BANK_DEFAULT[PORT_WIDTH-1:0],
  parameter bit                    DUAL_CONV    = 1'b1
) (
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [SPP_ADR_W-1:0]  wb_adr_i,
  input  wire logic [SPP_SEL_W-1:0]  wb_sel_i,
  input  wire logic [SPP_DATA_W-1:0] wb_dat_i,
  output logic      [SPP_DATA_W-1:0] wb_dat_o,
  output logic                       wb_ack_o,
  input  wire logic [PORT_WIDTH-1:0] pin_i,
  output logic      [PORT_WIDTH-1:0] pin_o,
  output logic      [PORT_WIDTH-1:0] pin_oe_o,
  input  wire logic [PORT_WIDTH-1:0] periph_enable_i,
  input  wire logic [PORT_WIDTH-1:0] periph_drive_i,
  input  wire logic [PORT_WIDTH-1:0] periph_out_i,
  output logic      [PORT_WIDTH-1:0] periph_in_o,
  output logic      [PORT_WIDTH-1:0] analog_en_o
);

  // ----------------------------------------------------------------
  // Writable bit masks
  // ----------------------------------------------------------------
  localparam logic [PORT_WIDTH-1:0] C1_LOW_MASK  = ANALOG_MASK & IMPL_MASK & ~ANALOG_BANK;
  localparam logic [PORT_WIDTH-1:0] C1_HIGH_MASK = ANALOG_MASK & IMPL_MASK & ANALOG_BANK;
  localparam logic [PORT_WIDTH-1:0] C2_LOW_MASK  = DUAL_CONV ? C1_LOW_MASK : '0;
  localparam logic [PORT_WIDTH-1:0] C2_HIGH_MASK = DUAL_CONV ? C1_HIGH_MASK : '0;
  localparam logic [PORT_WIDTH-1:0] DIR_INIT     = SPP_DIR_RESET[PORT_WIDTH-1:0] & IMPL_MASK;

  // ----------------------------------------------------------------
  // Registers and nets
  // ----------------------------------------------------------------
  logic [PORT_WIDTH-1:0] pin_direction_reg;
  logic [PORT_WIDTH-1:0] output_latch_reg;
  logic [PORT_WIDTH-1:0] open_drain_ctrl_reg;
  logic [PORT_WIDTH-1:0] c1_analog_select_low_reg;
  logic [PORT_WIDTH-1:0] c1_analog_select_high_reg;
  logic [PORT_WIDTH-1:0] c2_analog_select_low_reg;
  logic [PORT_WIDTH-1:0] c2_analog_select_high_reg;
  logic [PORT_WIDTH-1:0] pin_sync;
  logic [PORT_WIDTH-1:0] digital_c1;
  logic [PORT_WIDTH-1:0] digital_c2;
  logic [PORT_WIDTH-1:0] analog_mode;
  logic [PORT_WIDTH-1:0] periph_owns;
  logic [PORT_WIDTH-1:0] port_drives;
  logic [PORT_WIDTH-1:0] pin_out_next;
  logic [PORT_WIDTH-1:0] pin_oe_next;
  logic [PORT_WIDTH-1:0] periph_in_next;
  logic [PORT_WIDTH-1:0] pin_level_reg;
  logic [PORT_WIDTH-1:0] rd_value;
  logic                  wr_go;
  logic                  rd_go;

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic logic reg_hit(input logic [SPP_ADR_W-1:0] adr,
                                   input logic [SPP_ADR_W-1:0] off);
    return {adr[SPP_ADR_W-1:2], 2'b00} == off;
  endfunction : reg_hit

  function automatic logic [PORT_WIDTH-1:0] merge(input logic [PORT_WIDTH-1:0] old,
                                                  input logic [SPP_DATA_W-1:0] wdata,
                                                  input logic [SPP_SEL_W-1:0]  sel,
                                                  input logic [PORT_WIDTH-1:0] mask);
    logic [PORT_WIDTH-1:0] res;
    res = old;
    for (int i = 0; i < PORT_WIDTH; i++) begin
      if (sel[i/8]) begin
        res[i] = wdata[i];
      end
    end
    return res & mask;
  endfunction : merge

  assign wr_go = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
  assign rd_go = wb_cyc_i & wb_stb_i & ~wb_we_i & ~wb_ack_o;

  // ----------------------------------------------------------------
  // Pin synchronizer
  // ----------------------------------------------------------------
  spp_sync #(
    .WIDTH (PORT_WIDTH)
  ) u_sync (
    .clk_i   (clk_i),
    .async_i (pin_i),
    .sync_o  (pin_sync)
  );

  // ----------------------------------------------------------------
  // Analog mode
  // ----------------------------------------------------------------
  assign digital_c1  = (c1_analog_select_low_reg | c1_analog_select_high_reg) |
                       ~ANALOG_MASK;
  assign digital_c2  = DUAL_CONV ? ((c2_analog_select_low_reg | c2_analog_select_high_reg) |
                       ~ANALOG_MASK) : '1;
  assign analog_mode = IMPL_MASK & ANALOG_MASK & ~(digital_c1 & digital_c2);

  // ----------------------------------------------------------------
  // Pin cells
  // ----------------------------------------------------------------
  for (genvar g = 0; g < PORT_WIDTH; g++) begin : g_pin
    spp_pin_cell u_cell (
      .dir_i          (pin_direction_reg[g]),
      .latch_i        (output_latch_reg[g]),
      .od_i           (open_drain_ctrl_reg[g]),
      .periph_en_i    (periph_enable_i[g]),
      .periph_drive_i (periph_drive_i[g]),
      .periph_out_i   (periph_out_i[g]),
      .analog_i       (analog_mode[g]),
      .pin_sync_i     (pin_sync[g]),
      .impl_i         (IMPL_MASK[g]),
      .owns_o         (periph_owns[g]),
      .port_drives_o  (port_drives[g]),
      .pin_out_o      (pin_out_next[g]),
      .pin_oe_o       (pin_oe_next[g]),
      .periph_in_o    (periph_in_next[g]),
      .read_bit_o     (pin_level_reg[g])
    );
  end

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_direction_reg <= DIR_INIT;
    end else if (wr_go && reg_hit(wb_adr_i, SPP_OFF_DIR)) begin
      pin_direction_reg <= merge(pin_direction_reg, wb_dat_i, wb_sel_i, IMPL_MASK);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      output_latch_reg <= SPP_LATCH_RESET[PORT_WIDTH-1:0];
    end else if (wr_go && (reg_hit(wb_adr_i, SPP_OFF_LATCH) ||
                           reg_hit(wb_adr_i, SPP_OFF_LEVEL))) begin
      output_latch_reg <= merge(output_latch_reg, wb_dat_i, wb_sel_i, IMPL_MASK);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      open_drain_ctrl_reg <= SPP_OD_RESET[PORT_WIDTH-1:0];
    end else if (wr_go && reg_hit(wb_adr_i, SPP_OFF_OD)) begin
      open_drain_ctrl_reg <= merge(open_drain_ctrl_reg, wb_dat_i, wb_sel_i, IMPL_MASK);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      c1_analog_select_low_reg  <= SPP_ASEL_RESET[PORT_WIDTH-1:0];
      c1_analog_select_high_reg <= SPP_ASEL_RESET[PORT_WIDTH-1:0];
    end else if (wr_go && reg_hit(wb_adr_i, SPP_OFF_C1_LOW)) begin
      c1_analog_select_low_reg <= merge(c1_analog_select_low_reg, wb_dat_i, wb_sel_i,
                                        C1_LOW_MASK);
    end else if (wr_go && reg_hit(wb_adr_i, SPP_OFF_C1_HIGH)) begin
      c1_analog_select_high_reg <= merge(c1_analog_select_high_reg, wb_dat_i, wb_sel_i,
                                         C1_HIGH_MASK);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      c2_analog_select_low_reg  <= SPP_ASEL_RESET[PORT_WIDTH-1:0];
      c2_analog_select_high_reg <= SPP_ASEL_RESET[PORT_WIDTH-1:0];
    end else if (wr_go && reg_hit(wb_adr_i, SPP_OFF_C2_LOW)) begin
      c2_analog_select_low_reg <= merge(c2_analog_select_low_reg, wb_dat_i, wb_sel_i,
                                        C2_LOW_MASK);
    end else if (wr_go && reg_hit(wb_adr_i, SPP_OFF_C2_HIGH)) begin
      c2_analog_select_high_reg <= merge(c2_analog_select_high_reg, wb_dat_i, wb_sel_i,
                                         C2_HIGH_MASK);
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always_comb begin
    rd_value = '0;
    case ({wb_adr_i[SPP_ADR_W-1:2], 2'b00})
      SPP_OFF_DIR:     rd_value = pin_direction_reg;
      SPP_OFF_LATCH:   rd_value = output_latch_reg;
      SPP_OFF_LEVEL:   rd_value = pin_level_reg;
      SPP_OFF_OD:      rd_value = open_drain_ctrl_reg;
      SPP_OFF_C1_LOW:  rd_value = c1_analog_select_low_reg;
      SPP_OFF_C1_HIGH: rd_value = c1_analog_select_high_reg;
      SPP_OFF_C2_LOW:  rd_value = c2_analog_select_low_reg;
      SPP_OFF_C2_HIGH: rd_value = c2_analog_select_high_reg;
      default:         rd_value = '0;
    endcase
  end

  // ----------------------------------------------------------------
  // Bus answer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= '0;
    end else if (rd_go) begin
      wb_dat_o <= {16'h0000, SPP_REG_W'(rd_value)};
    end else begin
      wb_dat_o <= '0;
    end
  end

  // ----------------------------------------------------------------
  // Pin and peripheral outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_o    <= '0;
      pin_oe_o <= '0;
    end else begin
      pin_o    <= pin_out_next;
      pin_oe_o <= pin_oe_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      periph_in_o <= '0;
      analog_en_o <= '0;
    end else begin
      periph_in_o <= periph_in_next;
      analog_en_o <= analog_mode;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking

  default disable iff (rst_i);

  chk_reset_state: assert property (@(posedge clk_i) disable iff (1'b0)
    rst_i |=> (pin_direction_reg == DIR_INIT) && (pin_oe_o == '0) &&
              (c1_analog_select_low_reg == '0) && (c2_analog_select_low_reg == '0))
    else $error("reset did not leave pins as inputs in analog mode");

  chk_input_no_drive: assert property (
    1'b1 |=> ((pin_oe_o & $past(pin_direction_reg & ~periph_owns)) == '0))
    else $error("input pin is being driven");

  chk_periph_data_owns: assert property (
    1'b1 |=> (((pin_o ^ $past(periph_out_i)) &
               $past(periph_owns & ~open_drain_ctrl_reg)) == '0) &&
             ((~pin_oe_o & $past(periph_owns & ~open_drain_ctrl_reg)) == '0))
    else $error("peripheral does not own its driving pin");

  chk_port_idle_periph: assert property (
    1'b1 |=> (((pin_o ^ $past(output_latch_reg)) &
               $past(port_drives & ~open_drain_ctrl_reg)) == '0))
    else $error("port output not driven from latch");

  chk_no_loop_through: assert property (
    1'b1 |=> ((periph_in_o & $past(port_drives)) == '0))
    else $error("port output reached peripheral input");

  chk_latch_readback: assert property (
    (rd_go && reg_hit(wb_adr_i, SPP_OFF_LATCH)) |=>
      wb_ack_o && (wb_dat_o == {16'h0000, SPP_REG_W'($past(output_latch_reg))}))
    else $error("latch read returned wrong value");

  chk_level_write_latch: assert property (
    (wr_go && reg_hit(wb_adr_i, SPP_OFF_LEVEL) && (wb_sel_i == 4'hf)) |=>
      (output_latch_reg == ($past(wb_dat_i[PORT_WIDTH-1:0]) & IMPL_MASK)))
    else $error("level register write missed the latch");

  chk_unimpl_zero: assert property (
    ((pin_direction_reg | output_latch_reg | pin_oe_o | pin_level_reg) & ~IMPL_MASK) == '0)
    else $error("unimplemented bit not zero");

  chk_open_drain_low: assert property (
    1'b1 |=> ((pin_oe_o & pin_o & $past(open_drain_ctrl_reg)) == '0))
    else $error("open-drain pin driven high");

  chk_analog_reads_zero: assert property (
    (rd_go && reg_hit(wb_adr_i, SPP_OFF_LEVEL)) |=>
      ((wb_dat_o[PORT_WIDTH-1:0] & $past(analog_mode)) == '0))
    else $error("analog pin read as high");

  chk_sync_two_stage: assert property (
    ((pin_level_reg ^ $past(pin_i, 2)) & IMPL_MASK & ~analog_mode) == '0)
    else $error("pin level not two cycles behind pin");

  chk_converter_link: assert property (
    1'b1 |=> (analog_en_o == $past(analog_mode)) &&
             ((analog_en_o & ~$past(ANALOG_MASK & ~(digital_c1 & digital_c2))) == '0))
    else $error("converter connection wrong");

  chk_ack_single: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  chk_ack_answer: assert property (
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
    else $error("request not answered in one cycle");

  chk_dat_idle_zero: assert property (
    !wb_ack_o |-> (wb_dat_o == '0))
    else $error("read data not zero outside answer");

  // ----------------------------------------------------------------
  // Covers
  // ----------------------------------------------------------------
  cov_periph_takeover: cover property (
    (port_drives != '0) ##1 ((periph_owns & $past(port_drives)) != '0));

  cov_open_drain_low: cover property (
    (open_drain_ctrl_reg != '0) && ((pin_oe_o & ~pin_o) != '0));

  cov_analog_read: cover property (
    rd_go && reg_hit(wb_adr_i, SPP_OFF_LEVEL) && (analog_mode != '0));

  cov_level_write: cover property (
    wr_go && reg_hit(wb_adr_i, SPP_OFF_LEVEL));

endmodule : spp_port

// [rtl/spp_sync.sv]
// Purpose: Two-stage synchronizer for a vector of pin levels
// Assumes: Inputs are asynchronous to clk_i
// Notes:   Data only, no reset on the stages
`timescale 1ns/100ps
module spp_sync
  import spp_pkg::*;
#(
  parameter int WIDTH = SPP_MAX_WIDTH
) (
  input  wire logic             clk_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_reg;

  // ----------------------------------------------------------------
  // Stages
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    meta_reg <= async_i;
  end

  always_ff @(posedge clk_i) begin
    sync_o <= meta_reg;
  end

endmodule : spp_sync

// [testbench/spp_pin_partner.sv]
// Purpose: External circuitry on the shared pins
// Assumes: A pull-up on every pin line
// Notes:   Drives ext_val_i where enabled and the port is off
`timescale 1ns/100ps
module spp_pin_partner #(
  parameter int W = 16
) (
  input  wire logic [W-1:0] pin_o_i,
  input  wire logic [W-1:0] pin_oe_i,
  input  wire logic [W-1:0] ext_en_i,
  input  wire logic [W-1:0] ext_val_i,
  output logic      [W-1:0] pin_i_o
);
  // ----------------------------------------------------------------
  // Pin level
  // ----------------------------------------------------------------
  // Port wins where driven, else far side, else pull-up
  always_comb begin
    for (int i = 0; i < W; i++) begin
      pin_i_o[i] = pin_oe_i[i] ? pin_o_i[i] : (ext_en_i[i] ? ext_val_i[i] : 1'b1);
    end
  end
endmodule : spp_pin_partner

// [testbench/tb_spp_port.sv]
// Purpose: Self-checking bench for the shared pin parallel port
// Assumes: Partner model supplies pin levels
// Notes:   Reset checks first, then register rows, then pin ownership cases
`timescale 1ns/100ps
module tb_spp_port
  import spp_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam logic [15:0] IMPL = 16'h7fff;
  typedef struct packed {
    logic [SPP_ADR_W-1:0] wadr;
    logic [15:0]          wdat;
    logic [SPP_ADR_W-1:0] radr;
    logic [15:0]          exp;
  } spp_row_type;
  logic                  clk_i, rst_i, req, we, ack;
  logic [SPP_ADR_W-1:0]  adr;
  logic [SPP_SEL_W-1:0]  sel;
  logic [SPP_DATA_W-1:0] dat_w, dat_r;
  logic [15:0]           pin_i, pin_o, pin_oe, p_en, p_drv, p_out, p_in, ana;
  logic [15:0]           ext_en, ext_val, rd;
  int                    failures, compares;
  spp_row_type           rows [8];

  spp_port #(.IMPL_MASK(IMPL)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack),
    .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe), .periph_enable_i(p_en),
    .periph_drive_i(p_drv), .periph_out_i(p_out), .periph_in_o(p_in), .analog_en_o(ana));
  spp_pin_partner u_far (.pin_o_i(pin_o), .pin_oe_i(pin_oe), .ext_en_i(ext_en),
    .ext_val_i(ext_val), .pin_i_o(pin_i));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic bus(input logic w, input logic [SPP_ADR_W-1:0] a, input logic [15:0] d,
                     output logic [15:0] q);
    @(posedge clk_i);
    req <= 1'b1;
    we <= w;
    adr <= a;
    dat_w <= {16'h0000, d};
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    q = dat_r[15:0];
    req <= 1'b0;
    we <= 1'b0;
  endtask : bus

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic rchk(input string nm, input logic [SPP_ADR_W-1:0] a, input logic [15:0] e);
    bus(1'b0, a, 16'h0000, rd);
    chk(nm, e, rd);
  endtask : rchk

  task automatic settle;
    repeat (6) @(posedge clk_i);
  endtask : settle

  task automatic print_verdict;
    $display("Counts: %0d compares, %0d failures", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : print_verdict

  // ----------------------------------------------------------------
  // Clock, watchdog, sequence
  // ----------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  initial begin
    repeat (2000) @(posedge clk_i);
    failures++;
    print_verdict();
  end

  initial begin
    rows = '{'{SPP_OFF_DIR, 16'hffff, SPP_OFF_DIR, 16'h7fff},
             '{SPP_OFF_LATCH, 16'hffff, SPP_OFF_LATCH, 16'h7fff},
             '{SPP_OFF_LEVEL, 16'h1234, SPP_OFF_LATCH, 16'h1234},
             '{SPP_OFF_OD, 16'h8000, SPP_OFF_OD, 16'h0000},
             '{SPP_OFF_C1_LOW, 16'hffff, SPP_OFF_C1_LOW, 16'h003f},
             '{SPP_OFF_C1_HIGH, 16'hffff, SPP_OFF_C1_HIGH, 16'h00c0},
             '{SPP_OFF_C2_LOW, 16'hffff, SPP_OFF_C2_LOW, 16'h003f},
             '{SPP_OFF_C2_HIGH, 16'hffff, SPP_OFF_C2_HIGH, 16'h00c0}};
    rst_i = 1'b1;
    req = 1'b0;
    we = 1'b0;
    adr = '0;
    sel = 4'hf;
    dat_w = '0;
    p_en = '0;
    p_drv = '0;
    p_out = '0;
    ext_en = 16'hff00;
    ext_val = 16'hc300;
    failures = 0;
    compares = 0;
    repeat (12) @(posedge clk_i);
    chk("oe in reset", 16'h0000, pin_oe);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk("analog after reset", 16'h00ff, ana);
    rchk("dir reset", SPP_OFF_DIR, IMPL);
    rchk("select reset", SPP_OFF_C1_LOW, 16'h0000);
    $display("reset test done");
    foreach (rows[i]) begin
      bus(1'b1, rows[i].wadr, rows[i].wdat, rd);
      rchk("row read", rows[i].radr, rows[i].exp);
    end
    settle();
    chk("all digital", 16'h0000, ana);
    $display("register rows done");
    bus(1'b1, SPP_OFF_DIR, 16'hff00, rd);
    bus(1'b1, SPP_OFF_LATCH, 16'h005a, rd);
    settle();
    chk("port oe", 16'h00ff, pin_oe);
    chk("port out", 16'h005a, pin_o & pin_oe);
    rchk("level", SPP_OFF_LEVEL, 16'h435a);
    $display("port drive test done");
    p_en <= 16'h0003;
    p_drv <= 16'h0001;
    p_out <= 16'h0001;
    settle();
    chk("shared oe", 16'h00ff, pin_oe);
    chk("shared out", 16'h005b, pin_o & pin_oe);
    chk("periph in", 16'h4301, p_in & IMPL);
    rchk("shared level", SPP_OFF_LEVEL, 16'h435b);
    $display("peripheral test done");
    bus(1'b1, SPP_OFF_OD, 16'h000f, rd);
    settle();
    chk("od oe", 16'h00f4, pin_oe);
    chk("od out", 16'h0050, pin_o & pin_oe);
    rchk("od level", SPP_OFF_LEVEL, 16'h435b);
    $display("open drain test done");
    bus(1'b1, SPP_OFF_DIR, 16'hff3f, rd);
    bus(1'b1, SPP_OFF_C1_LOW, 16'h0000, rd);
    settle();
    chk("analog map", 16'h003f, ana);
    rchk("analog level", SPP_OFF_LEVEL, 16'h4340);
    chk("analog periph in", 16'h4300, p_in & IMPL);
    bus(1'b1, SPP_OFF_C1_LOW, 16'hffff, rd);
    bus(1'b1, SPP_OFF_C2_LOW, 16'h0000, rd);
    settle();
    chk("second converter map", 16'h003f, ana);
    rchk("second converter level", SPP_OFF_LEVEL, 16'h4340);
    $display("analog test done");
    p_en <= '0;
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk("oe after reset", 16'h0000, pin_oe);
    chk("analog after reset", 16'h00ff, ana);
    $display("second reset test done");
    print_verdict();
  end
endmodule : tb_spp_port
